// >>> core/regchg_regs.svh
// constants for the register-change decoder: opcodes, values, reset values
//
// Contract
// - opcode 0210 replaces accumulator with its ones complement; index unchanged.
// - opcode 0528 loads index with plus one.
// - opcode 0008 loads index with minus one (all ones).
// - opcode 0408 replaces index with its ones complement.
// - 13C0 copies accumulator lsb into flag; 13A0 copies index lsb.
// - opcode 0118 clears accumulator and index together.
// - opcode 0358 loads accumulator and index with plus one.
// - opcode 0018 loads accumulator and index with minus one.
// - opcode 0208 puts ones complement of accumulator in index.
// - opcode 0410 puts ones complement of index in accumulator.
// - opcode 0308 puts negated accumulator in index.
// - opcode 0510 puts negated index in accumulator.
// - opcode 0148 puts accumulator plus one in index.
// - opcode 0130 puts index plus one in accumulator.
// - opcode 0090 puts program counter plus one in index.
// - opcode 00C8 puts accumulator minus one in index.
// - extended variant, 0218 fetches and executes the word addressed by index.
// - opcode 1C05 loads accumulator from console data, then halts.
// - opcode 5804 loads accumulator from console data, no halt.
// - opcode 5801 loads accumulator from console sense register.
// - opcode 1C09 loads index from console data, then halts.
// - 4404 writes accumulator to console data; 1C10 writes location, halts.
`ifndef REGCHG_REGS_SVH
`define REGCHG_REGS_SVH
`define RC_W 16
`define OPC_ONES_COMP_ACC 16'h0210
`define OPC_INDEX_SET_PLUS_ONE 16'h0528
`define OPC_INDEX_SET_MINUS_ONE 16'h0008
`define OPC_INDEX_ONES_COMP 16'h0408
`define OPC_ACC_LSB_TO_FLAG 16'h13c0
`define OPC_INDEX_LSB_TO_FLAG 16'h13a0
`define OPC_CLEAR_BOTH_REGS 16'h0118
`define OPC_BOTH_REGS_PLUS_ONE 16'h0358
`define OPC_BOTH_REGS_MINUS_ONE 16'h0018
`define OPC_ACC_COMP_INTO_INDEX 16'h0208
`define OPC_INDEX_COMP_INTO_ACC 16'h0410
`define OPC_ACC_NEG_INTO_INDEX 16'h0308
`define OPC_INDEX_NEG_INTO_ACC 16'h0510
`define OPC_ACC_INC_INTO_INDEX 16'h0148
`define OPC_INDEX_INC_INTO_ACC 16'h0130
`define OPC_PC_INC_INTO_INDEX 16'h0090
`define OPC_ACC_DEC_INTO_INDEX 16'h00c8
`define OPC_EXECUTE_VIA_INDEX 16'h0218
`define OPC_CONSOLE_TO_ACC_HALT 16'h1c05
`define OPC_CONSOLE_DATA_TO_ACC 16'h5804
`define OPC_CONSOLE_SENSE_TO_ACC 16'h5801
`define OPC_CONSOLE_TO_INDEX_HALT 16'h1c09
`define OPC_ACC_TO_CONSOLE_DATA 16'h4404
`define OPC_LOCATION_TO_CONSOLE_HALT 16'h1c10
`define VAL_ZERO 16'h0000
`define VAL_ONE 16'h0001
`define VAL_ALL_ONES 16'hffff
`define RST_WORD 16'h0000
`define RST_FLAG 1'b0
`define LSB_POS 0
`endif

// >>> core/regchg_pkg.sv
// types shared by the register-change decoder modules
package regchg_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [4:0] {
    op_ones_comp_acc, op_index_set_plus_one, op_index_set_minus_one,
    op_index_ones_comp, op_acc_lsb_to_flag, op_index_lsb_to_flag,
    op_clear_both_regs, op_both_regs_plus_one, op_both_regs_minus_one,
    op_acc_comp_into_index, op_index_comp_into_acc, op_acc_neg_into_index,
    op_index_neg_into_acc, op_acc_inc_into_index, op_index_inc_into_acc,
    op_pc_inc_into_index, op_acc_dec_into_index, op_execute_via_index,
    op_console_to_acc_halt, op_console_data_to_acc, op_console_sense_to_acc,
    op_console_to_index_halt, op_acc_to_console_data,
    op_location_to_console_halt, op_unknown
  } op_e;
  typedef enum logic [1:0] {
    st_idle, st_fetch_target, st_halted
  } state_e;
endpackage

// >>> core/regchg_dec_if.sv
// carrier between the control module and the opcode matcher
`timescale 1ns/1ps
interface regchg_dec_if;
  import regchg_pkg::*;
  word_t word;
  op_e op;
  // matcher side
  modport dec (
    input word,
    output op
  );
  // control side
  modport ctl (
    output word,
    input op
  );
endinterface // regchg_dec_if

// >>> core/opcode_match.sv
// opcode matcher: exact skeleton compare, one operation out
`timescale 1ns/1ps
`include "regchg_regs.svh"
module opcode_match #(
  parameter bit EXTENDED_EN = 1'b1
) (
  // instruction word in, operation out
  regchg_dec_if.dec dif
);
  import regchg_pkg::*;

  // full-word match; skeletons with illegible codes are simply not matched
  always_comb begin
    unique case (dif.word)
      `OPC_ONES_COMP_ACC: dif.op = op_ones_comp_acc;
      `OPC_INDEX_SET_PLUS_ONE: dif.op = op_index_set_plus_one;
      `OPC_INDEX_SET_MINUS_ONE: dif.op = op_index_set_minus_one;
      `OPC_INDEX_ONES_COMP: dif.op = op_index_ones_comp;
      `OPC_ACC_LSB_TO_FLAG: dif.op = op_acc_lsb_to_flag;
      `OPC_INDEX_LSB_TO_FLAG: dif.op = op_index_lsb_to_flag;
      `OPC_CLEAR_BOTH_REGS: dif.op = op_clear_both_regs;
      `OPC_BOTH_REGS_PLUS_ONE: dif.op = op_both_regs_plus_one;
      `OPC_BOTH_REGS_MINUS_ONE: dif.op = op_both_regs_minus_one;
      `OPC_ACC_COMP_INTO_INDEX: dif.op = op_acc_comp_into_index;
      `OPC_INDEX_COMP_INTO_ACC: dif.op = op_index_comp_into_acc;
      `OPC_ACC_NEG_INTO_INDEX: dif.op = op_acc_neg_into_index;
      `OPC_INDEX_NEG_INTO_ACC: dif.op = op_index_neg_into_acc;
      `OPC_ACC_INC_INTO_INDEX: dif.op = op_acc_inc_into_index;
      `OPC_INDEX_INC_INTO_ACC: dif.op = op_index_inc_into_acc;
      `OPC_PC_INC_INTO_INDEX: dif.op = op_pc_inc_into_index;
      `OPC_ACC_DEC_INTO_INDEX: dif.op = op_acc_dec_into_index;
      // only the extended variant knows the indirect execute
      `OPC_EXECUTE_VIA_INDEX: dif.op = EXTENDED_EN ? op_execute_via_index : op_unknown;
      `OPC_CONSOLE_TO_ACC_HALT: dif.op = op_console_to_acc_halt;
      `OPC_CONSOLE_DATA_TO_ACC: dif.op = op_console_data_to_acc;
      `OPC_CONSOLE_SENSE_TO_ACC: dif.op = op_console_sense_to_acc;
      `OPC_CONSOLE_TO_INDEX_HALT: dif.op = op_console_to_index_halt;
      `OPC_ACC_TO_CONSOLE_DATA: dif.op = op_acc_to_console_data;
      `OPC_LOCATION_TO_CONSOLE_HALT: dif.op = op_location_to_console_halt;
      default: dif.op = op_unknown;
    endcase
  end
endmodule // opcode_match

// >>> core/register_change_decoder.sv
// register-change instruction executor: accumulator, index, flag, console data
`timescale 1ns/1ps
`include "regchg_regs.svh"
module register_change_decoder #(
  parameter bit EXTENDED_EN = 1'b1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // instruction from fetch
  input wire logic instr_valid_i,
  input wire regchg_pkg::word_t instr_i,
  input wire regchg_pkg::word_t instr_loc_i,
  input wire regchg_pkg::word_t pc_i,
  output logic instr_ready_o,
  output logic retire_o,
  output logic unknown_o,
  // indirect target fetch
  output logic target_req_o,
  output regchg_pkg::word_t target_addr_o,
  input wire logic target_valid_i,
  input wire regchg_pkg::word_t target_word_i,
  // operator console
  input wire regchg_pkg::word_t console_sense_i,
  input wire logic console_load_i,
  input wire regchg_pkg::word_t console_value_i,
  input wire logic resume_i,
  output regchg_pkg::word_t console_data_o,
  output logic halted_o,
  // register file view
  output regchg_pkg::word_t acc_o,
  output regchg_pkg::word_t index_o,
  output logic arith_excess_flag_o
);
  import regchg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // increment, shared by negate and the three increment forms
  function automatic word_t add_one(input word_t v);
    add_one = word_t'(v + `VAL_ONE);
  endfunction

  // two's complement negation
  function automatic word_t negate(input word_t v);
    negate = add_one(~v);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_sync_n;

  // async assert, release through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_sync_n = rst_sync_ff;

  //////////////////////////////////////////////////////////////////////////
  // state

  state_e state_ff;
  state_e nxt_state;
  word_t acc_ff;
  word_t nxt_acc;
  word_t index_ff;
  word_t nxt_index;
  logic flag_ff;
  logic nxt_flag;
  word_t console_ff;
  word_t nxt_console;
  word_t ctx_pc_ff;
  word_t ctx_loc_ff;
  logic ready_ff;
  logic nxt_ready;
  logic retire_ff;
  logic unknown_ff;
  logic halted_ff;
  logic target_req_ff;
  word_t target_addr_ff;

  logic take;
  logic exec_go;
  word_t exec_word;
  word_t exec_pc;
  word_t exec_loc;
  logic halt_req;
  logic fetch_req;
  logic is_unknown;

  //////////////////////////////////////////////////////////////////////////
  // decode

  regchg_dec_if dif ();

  opcode_match #(
    .EXTENDED_EN(EXTENDED_EN)
  ) u_match (
    .dif(dif)
  );

  // a new word is taken only when ready was offered
  assign take = (state_ff == st_idle) && ready_ff && instr_valid_i;
  // the indirect target runs in place of a fresh fetch
  assign exec_go = take || ((state_ff == st_fetch_target) && target_valid_i);
  assign exec_word = (state_ff == st_fetch_target) ? target_word_i : instr_i;
  // the target keeps the context of the instruction that pointed at it
  assign exec_pc = (state_ff == st_fetch_target) ? ctx_pc_ff : pc_i;
  assign exec_loc = (state_ff == st_fetch_target) ? ctx_loc_ff : instr_loc_i;
  assign dif.word = exec_word;

  //////////////////////////////////////////////////////////////////////////
  // datapath next values

  // every destination defaults to its own value; only named ones move
  always_comb begin
    nxt_acc = acc_ff;
    nxt_index = index_ff;
    nxt_flag = flag_ff;
    nxt_console = console_ff;
    halt_req = 1'b0;
    fetch_req = 1'b0;
    is_unknown = 1'b0;
    if (exec_go) begin
      unique case (dif.op)
        op_ones_comp_acc: nxt_acc = ~acc_ff;
        op_index_set_plus_one: nxt_index = `VAL_ONE;
        op_index_set_minus_one: nxt_index = `VAL_ALL_ONES;
        op_index_ones_comp: nxt_index = ~index_ff;
        op_acc_lsb_to_flag: nxt_flag = acc_ff[`LSB_POS];
        op_index_lsb_to_flag: nxt_flag = index_ff[`LSB_POS];
        op_clear_both_regs: begin
          nxt_acc = `VAL_ZERO;
          nxt_index = `VAL_ZERO;
        end
        op_both_regs_plus_one: begin
          nxt_acc = `VAL_ONE;
          nxt_index = `VAL_ONE;
        end
        op_both_regs_minus_one: begin
          nxt_acc = `VAL_ALL_ONES;
          nxt_index = `VAL_ALL_ONES;
        end
        op_acc_comp_into_index: nxt_index = ~acc_ff;
        op_index_comp_into_acc: nxt_acc = ~index_ff;
        op_acc_neg_into_index: nxt_index = negate(acc_ff);
        op_index_neg_into_acc: nxt_acc = negate(index_ff);
        op_acc_inc_into_index: nxt_index = add_one(acc_ff);
        op_index_inc_into_acc: nxt_acc = add_one(index_ff);
        op_pc_inc_into_index: nxt_index = add_one(exec_pc);
        op_acc_dec_into_index: nxt_index = word_t'(acc_ff - `VAL_ONE);
        op_execute_via_index: fetch_req = 1'b1;
        op_console_to_acc_halt: begin
          nxt_acc = console_ff;
          halt_req = 1'b1;
        end
        op_console_data_to_acc: nxt_acc = console_ff;
        op_console_sense_to_acc: nxt_acc = console_sense_i;
        op_console_to_index_halt: begin
          nxt_index = console_ff;
          halt_req = 1'b1;
        end
        op_acc_to_console_data: nxt_console = acc_ff;
        op_location_to_console_halt: begin
          nxt_console = exec_loc;
          halt_req = 1'b1;
        end
        op_unknown: is_unknown = 1'b1;
      endcase
    end else if (console_load_i) begin
      // operator entry only lands when no instruction executes this cycle
      nxt_console = console_value_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencing

  // halt and indirect fetch hold off the next instruction
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      st_idle: begin
        if (exec_go && halt_req) begin
          nxt_state = st_halted;
        end else if (exec_go && fetch_req) begin
          nxt_state = st_fetch_target;
        end
      end
      st_fetch_target: begin
        if (exec_go && halt_req) begin
          nxt_state = st_halted;
        end else if (exec_go && !fetch_req) begin
          nxt_state = st_idle;
        end
      end
      st_halted: begin
        if (resume_i) begin
          nxt_state = st_idle;
        end
      end
    endcase
  end

  // ready falls for at least one cycle after a take so updates land first
  assign nxt_ready = (nxt_state == st_idle) && !exec_go;

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // architectural registers

  // all destinations of one instruction load on the same edge
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_ff <= `RST_WORD;
      index_ff <= `RST_WORD;
    end else begin
      acc_ff <= nxt_acc;
      index_ff <= nxt_index;
    end
  end

  // flag moves only on the two lsb-copy operations
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_ff <= `RST_FLAG;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // console data: instruction output or operator entry
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      console_ff <= `RST_WORD;
    end else begin
      console_ff <= nxt_console;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // indirect execute

  // context is kept so a pointed-at word sees the pointer's location
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctx_pc_ff <= `RST_WORD;
      ctx_loc_ff <= `RST_WORD;
    end else if (take) begin
      ctx_pc_ff <= pc_i;
      ctx_loc_ff <= instr_loc_i;
    end
  end

  // request stays up until the target word arrives; a chained pointer
  // re-requests using the index value of that same edge
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      target_req_ff <= 1'b0;
      target_addr_ff <= `RST_WORD;
    end else begin
      target_req_ff <= (nxt_state == st_fetch_target);
      if (exec_go && fetch_req) begin
        target_addr_ff <= index_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // handshake and status

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  // retire marks the edge on which the results became visible
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      retire_ff <= 1'b0;
      unknown_ff <= 1'b0;
    end else begin
      retire_ff <= exec_go && !fetch_req;
      unknown_ff <= exec_go && is_unknown;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      halted_ff <= 1'b0;
    end else begin
      halted_ff <= (nxt_state == st_halted);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign instr_ready_o = ready_ff;
  assign retire_o = retire_ff;
  assign unknown_o = unknown_ff;
  assign target_req_o = target_req_ff;
  assign target_addr_o = target_addr_ff;
  assign console_data_o = console_ff;
  assign halted_o = halted_ff;
  assign acc_o = acc_ff;
  assign index_o = index_ff;
  assign arith_excess_flag_o = flag_ff;
endmodule // register_change_decoder

// >>> bench/regchg_checker_props.sv
// port-level assertion checker for the register-change decoder
`timescale 1ns/1ps
`include "regchg_regs.svh"
module regchg_checker_props #(
  parameter bit EXTENDED_EN = 1'b1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // instruction side
  input wire logic instr_valid_i,
  input wire regchg_pkg::word_t instr_i,
  input wire regchg_pkg::word_t pc_i,
  input wire logic instr_ready_o,
  input wire logic retire_o,
  input wire logic unknown_o,
  input wire logic target_req_o,
  input wire regchg_pkg::word_t target_addr_o,
  // register view
  input wire regchg_pkg::word_t console_data_o,
  input wire logic halted_o,
  input wire regchg_pkg::word_t acc_o,
  input wire regchg_pkg::word_t index_o,
  input wire logic arith_excess_flag_o
);
  import regchg_pkg::*;
  logic take;
  // a word is taken only on an edge where ready and valid meet
  assign take = instr_valid_i && instr_ready_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  chk_comp_acc_only: assert property (
    take && instr_i == `OPC_ONES_COMP_ACC |=> acc_o == ~$past(acc_o) && $stable(index_o))
    else $error("ones complement of accumulator wrong");
  chk_index_plus_one: assert property (
    take && instr_i == `OPC_INDEX_SET_PLUS_ONE |=> index_o == `VAL_ONE)
    else $error("index not set to plus one");
  chk_index_minus_one: assert property (
    take && instr_i == `OPC_INDEX_SET_MINUS_ONE |=> index_o == `VAL_ALL_ONES)
    else $error("index not set to minus one");
  chk_clear_both: assert property (
    take && instr_i == `OPC_CLEAR_BOTH_REGS |=> acc_o == `VAL_ZERO && index_o == `VAL_ZERO)
    else $error("accumulator and index not cleared");
  chk_neg_into_index: assert property (
    take && instr_i == `OPC_ACC_NEG_INTO_INDEX |=> index_o == 16'h0000 - $past(acc_o))
    else $error("negated accumulator not in index");
  chk_pc_into_index: assert property (
    take && instr_i == `OPC_PC_INC_INTO_INDEX |=> index_o == $past(pc_i) + 16'h0001)
    else $error("program counter plus one not in index");
  chk_console_halt: assert property (
    take && instr_i == `OPC_CONSOLE_TO_ACC_HALT |=>
      halted_o && retire_o && acc_o == $past(console_data_o))
    else $error("console load and halt wrong");
  chk_target_fetch: assert property (
    take && EXTENDED_EN && instr_i == `OPC_EXECUTE_VIA_INDEX |=>
      target_req_o && !retire_o && target_addr_o == $past(index_o))
    else $error("indirect fetch not requested from index");
  chk_single_step: assert property (
    take && instr_i != `OPC_EXECUTE_VIA_INDEX |=> retire_o ##1 !retire_o)
    else $error("retire not one cycle after take");
  chk_unknown_keeps: assert property (
    unknown_o |-> retire_o && $stable(acc_o) && $stable(index_o)
      && $stable(arith_excess_flag_o))
    else $error("unknown word changed registers");
endmodule // regchg_checker_props

bind register_change_decoder regchg_checker_props #(.EXTENDED_EN(EXTENDED_EN)) u_props (
  .core_clk_i, .rst_n_i, .instr_valid_i, .instr_i, .pc_i, .instr_ready_o, .retire_o,
  .unknown_o, .target_req_o, .target_addr_o, .console_data_o, .halted_o, .acc_o,
  .index_o, .arith_excess_flag_o
);

// >>> bench/regchg_fetch_model.sv
// fetch-side responder that returns indirect target words
`timescale 1ns/1ps
module regchg_fetch_model (
  // clock
  input wire logic clk_i,
  // request from the block, word and delay wanted by the bench
  input wire logic req_i,
  input wire regchg_pkg::word_t word_i,
  input wire logic [3:0] delay_i,
  // answer
  output logic valid_o = 1'b0,
  output regchg_pkg::word_t word_o = 16'h0000
);
  import regchg_pkg::*;
  logic [3:0] wait_ff = 4'h0;
  // one-cycle answer after the delay; data toggles otherwise so stale words never look valid
  always_ff @(posedge clk_i) begin
    if (!req_i || valid_o) begin
      wait_ff <= 4'h0;
      valid_o <= 1'b0;
      word_o <= ~word_o;
    end else if (wait_ff >= delay_i) begin
      valid_o <= 1'b1;
      word_o <= word_i;
    end else begin
      wait_ff <= wait_ff + 4'h1;
      word_o <= ~word_o;
    end
  end
endmodule // regchg_fetch_model

// >>> bench/register_change_decoder_test.sv
// self-checking bench for the register-change decoder
`timescale 1ns/1ps
`include "regchg_regs.svh"
module register_change_decoder_test;
  import regchg_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic console_load_i = 1'b0;
  logic resume_i = 1'b0;
  logic target_valid_i;
  word_t instr_i = 16'h0000;
  word_t instr_loc_i = 16'h0000;
  word_t pc_i = 16'h0000;
  word_t console_sense_i = 16'h0000;
  word_t console_value_i = 16'h0000;
  word_t target_word_i;
  logic instr_ready_o, retire_o, unknown_o, target_req_o, halted_o, arith_excess_flag_o;
  word_t target_addr_o, console_data_o, acc_o, index_o;
  word_t tgt_word = 16'h0000;
  logic [3:0] tgt_delay = 4'h0;
  word_t rnd = 16'h004c;
  word_t m_acc, m_idx, m_cd;
  logic m_flg, m_hlt, m_unk;
  int err_count = 0;
  int n_tests = 0;
  // every skeleton; the indirect one sits last so targets can skip it
  word_t ops[24] = '{`OPC_ONES_COMP_ACC, `OPC_INDEX_SET_PLUS_ONE, `OPC_INDEX_SET_MINUS_ONE,
    `OPC_INDEX_ONES_COMP, `OPC_ACC_LSB_TO_FLAG, `OPC_INDEX_LSB_TO_FLAG, `OPC_CLEAR_BOTH_REGS,
    `OPC_BOTH_REGS_PLUS_ONE, `OPC_BOTH_REGS_MINUS_ONE, `OPC_ACC_COMP_INTO_INDEX,
    `OPC_INDEX_COMP_INTO_ACC, `OPC_ACC_NEG_INTO_INDEX, `OPC_INDEX_NEG_INTO_ACC,
    `OPC_ACC_INC_INTO_INDEX, `OPC_INDEX_INC_INTO_ACC, `OPC_PC_INC_INTO_INDEX,
    `OPC_ACC_DEC_INTO_INDEX, `OPC_CONSOLE_TO_ACC_HALT, `OPC_CONSOLE_DATA_TO_ACC,
    `OPC_CONSOLE_SENSE_TO_ACC, `OPC_CONSOLE_TO_INDEX_HALT, `OPC_ACC_TO_CONSOLE_DATA,
    `OPC_LOCATION_TO_CONSOLE_HALT, `OPC_EXECUTE_VIA_INDEX};
  ////////////////////////////////////////////////////////////////////////////////
  // 20 ns clock
  always #10 core_clk_i = ~core_clk_i;
  register_change_decoder u_dut (.*);
  regchg_fetch_model u_fetch (.clk_i(core_clk_i), .req_i(target_req_o), .word_i(tgt_word),
    .delay_i(tgt_delay), .valid_o(target_valid_i), .word_o(target_word_i));
  ////////////////////////////////////////////////////////////////////////////////
  // linear feedback shift register step
  function automatic void step();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
  endfunction
  // reference effect of one instruction on the bench's register copies
  function automatic void predict(word_t w, word_t pc, word_t loc, word_t sense);
    m_hlt = 1'b0;
    m_unk = 1'b0;
    case (w)
      `OPC_ONES_COMP_ACC: m_acc = ~m_acc;
      `OPC_INDEX_SET_PLUS_ONE: m_idx = `VAL_ONE;
      `OPC_INDEX_SET_MINUS_ONE: m_idx = `VAL_ALL_ONES;
      `OPC_INDEX_ONES_COMP: m_idx = ~m_idx;
      `OPC_ACC_LSB_TO_FLAG: m_flg = m_acc[0];
      `OPC_INDEX_LSB_TO_FLAG: m_flg = m_idx[0];
      `OPC_CLEAR_BOTH_REGS: {m_acc, m_idx} = {2{`VAL_ZERO}};
      `OPC_BOTH_REGS_PLUS_ONE: {m_acc, m_idx} = {2{`VAL_ONE}};
      `OPC_BOTH_REGS_MINUS_ONE: {m_acc, m_idx} = {2{`VAL_ALL_ONES}};
      `OPC_ACC_COMP_INTO_INDEX: m_idx = ~m_acc;
      `OPC_INDEX_COMP_INTO_ACC: m_acc = ~m_idx;
      `OPC_ACC_NEG_INTO_INDEX: m_idx = 16'h0000 - m_acc;
      `OPC_INDEX_NEG_INTO_ACC: m_acc = 16'h0000 - m_idx;
      `OPC_ACC_INC_INTO_INDEX: m_idx = m_acc + 16'h0001;
      `OPC_INDEX_INC_INTO_ACC: m_acc = m_idx + 16'h0001;
      `OPC_PC_INC_INTO_INDEX: m_idx = pc + 16'h0001;
      `OPC_ACC_DEC_INTO_INDEX: m_idx = m_acc - 16'h0001;
      `OPC_CONSOLE_TO_ACC_HALT: {m_acc, m_hlt} = {m_cd, 1'b1};
      `OPC_CONSOLE_DATA_TO_ACC: m_acc = m_cd;
      `OPC_CONSOLE_SENSE_TO_ACC: m_acc = sense;
      `OPC_CONSOLE_TO_INDEX_HALT: {m_idx, m_hlt} = {m_cd, 1'b1};
      `OPC_ACC_TO_CONSOLE_DATA: m_cd = m_acc;
      `OPC_LOCATION_TO_CONSOLE_HALT: {m_cd, m_hlt} = {loc, 1'b1};
      default: m_unk = 1'b1;
    endcase
  endfunction
  task automatic check(string what, word_t exp, word_t got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // operator writes the console data register while no instruction runs
  task automatic load(word_t v);
    @(negedge core_clk_i);
    console_load_i = 1'b1;
    console_value_i = v;
    @(negedge core_clk_i);
    console_load_i = 1'b0;
    m_cd = v;
  endtask
  // offer one word, follow it to retirement, compare, and resume from any halt
  task automatic run(word_t w, word_t tgt);
    int n;
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
    step();
    pc_i = rnd;
    instr_loc_i = ~rnd;
    console_sense_i = rnd ^ 16'h5a5a;
    tgt_word = tgt;
    tgt_delay = rnd[3:0];
    instr_i = w;
    instr_valid_i = 1'b1;
    @(negedge core_clk_i);
    instr_valid_i = 1'b0;
    if (w === `OPC_EXECUTE_VIA_INDEX) begin
      check("target request", 16'h0001, {15'h0000, target_req_o});
      check("target address", m_idx, target_addr_o);
      predict(tgt, pc_i, instr_loc_i, console_sense_i);
      n = 0;
      while (retire_o !== 1'b1 && n < 40) begin
        @(negedge core_clk_i);
        n++;
      end
    end else begin
      predict(w, pc_i, instr_loc_i, console_sense_i);
    end
    check("retire", 16'h0001, {15'h0000, retire_o});
    check("unknown", {15'h0000, m_unk}, {15'h0000, unknown_o});
    check("accumulator", m_acc, acc_o);
    check("index", m_idx, index_o);
    check("flag", {15'h0000, m_flg}, {15'h0000, arith_excess_flag_o});
    check("console data", m_cd, console_data_o);
    check("halted", {15'h0000, m_hlt}, {15'h0000, halted_o});
    if (m_hlt) begin
      resume_i = 1'b1;
      @(negedge core_clk_i);
      resume_i = 1'b0;
      check("halted after resume", 16'h0000, {15'h0000, halted_o});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard sized well above the expected run length
  initial begin
    #(20 * 40000);
    err_count++;
    end_sim();
  end
  // main sequence: random accumulator and index before each pair of skeletons (index all ones in round 0), three rounds
  initial begin
    {m_acc, m_idx, m_cd, m_flg} = '0;
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    // the block holds its registers in reset two more edges; an earlier console load is lost
    repeat (3) @(negedge core_clk_i);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 24; k++) begin
        step();
        load(rnd);
        run(`OPC_CONSOLE_DATA_TO_ACC, 16'h0000);
        step();
        load(r == 0 ? 16'hffff : rnd);
        run(`OPC_CONSOLE_TO_INDEX_HALT, 16'h0000);
        step();
        run(ops[k], ops[rnd % 23]);
        run(ops[(k + 5) % 24], ops[(rnd >> 3) % 23]);
      end
    end
    run(16'h1234, 16'h0000);
    run(`OPC_CLEAR_BOTH_REGS, 16'h0000);
    run(`OPC_EXECUTE_VIA_INDEX, `OPC_LOCATION_TO_CONSOLE_HALT);
    end_sim();
  end
endmodule // register_change_decoder_test
